// >>> logic/dual_slope_symmetric_pwm_timer.sv
/*
 * phase and frequency correct pwm timer with two compare channels.
 * assumes configuration inputs come from logic on ref_clk_i, and that
 * software clears flags by a one-cycle pulse on flag_clear_i.
 */
// Notes on behaviour
// (R1) count up to TOP; TOP from capture or compare A
// (R2) hold TOP one tick before counting down
// (R3) counter equal compare sets matching flag
// (R4) at BOTTOM set overflow, load compare buffers
// (R5) TOP reached sets compare A or capture flag
// (R6) compare above TOP never matches
// (R7) software keeps TOP at least every compare value
// (R8) mode two non-inverted, three inverted output
// (R9) pin driven only when direction selects output
// (R10) match up sets one way, down the other
// (R11) tick divides clock by 1, 8, 64, 256, 1024
// (R12) compare at BOTTOM or TOP gives constant level
// (R13) synchronous counter, tick is clock enable
// (R14) software varies frequency using compare A as TOP
// (R15) count down to zero then count up again
`timescale 1ns/1ps
module dual_slope_symmetric_pwm_timer #(
    parameter int CNT_W = pwm_timer_pkg::CNT_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] waveform_mode_select_i,
    input wire logic [2:0] prescale_select_i,
    input wire pwm_timer_pkg::output_modes_s output_mode_bits_i,
    input wire logic [CNT_W-1:0] compare_a_buffer_i,
    input wire logic [CNT_W-1:0] compare_b_buffer_i,
    input wire logic [CNT_W-1:0] capture_top_register_i,
    input wire logic [1:0] pin_direction_bit_i,
    input wire pwm_timer_pkg::timer_flags_s flag_clear_i,
    output logic [CNT_W-1:0] pwm_counter_o,
    output logic [CNT_W-1:0] compare_register_a_o,
    output logic [CNT_W-1:0] compare_register_b_o,
    output pwm_timer_pkg::timer_flags_s flags_o,
    output logic [1:0] pwm_outputs_o,
    output logic [1:0] pin_level_o,
    output logic [1:0] pin_oe_o,
    output logic timer_tick_o
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] ocr_a_reg;
    logic [CNT_W-1:0] ocr_b_reg;
    logic [CNT_W-1:0] top;
    logic [pwm_timer_pkg::PRESCALE_W-1:0] presc_reg;
    logic tick;
    logic mode_ok;
    logic match_a;
    logic match_b;
    logic at_top;
    logic at_bottom;
    logic [1:0] wave_reg;
    pwm_timer_pkg::dir_state_e dir_reg;
    pwm_timer_pkg::dir_state_e dir_next;
    pwm_timer_pkg::timer_flags_s flags_reg;
    pwm_timer_pkg::timer_flags_s flag_set;

    // pwm level for one channel after an up or down compare match
    function automatic logic match_level(input logic [1:0] mode, input logic counting_up);
        match_level = (mode == pwm_timer_pkg::OUT_MODE_INV) ? counting_up : ~counting_up;
    endfunction : match_level

    // free-running prescaler; tick is a one-cycle enable
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || prescale_select_i == pwm_timer_pkg::PRESCALE_OFF) begin
            presc_reg <= pwm_timer_pkg::PRESCALE_RESET;
        end else begin
            presc_reg <= presc_reg + 10'h001;
        end
    end

    always_comb begin
        unique case (prescale_select_i)
            pwm_timer_pkg::PRESCALE_1: tick = 1'b1; // see (R11) (R13)
            pwm_timer_pkg::PRESCALE_8: tick = (presc_reg[2:0] == 3'h7); // see (R11)
            pwm_timer_pkg::PRESCALE_64: tick = (presc_reg[5:0] == 6'h3f);
            pwm_timer_pkg::PRESCALE_256: tick = (presc_reg[7:0] == 8'hff);
            pwm_timer_pkg::PRESCALE_1024: tick = (presc_reg == 10'h3ff);
            default: tick = 1'b0;
        endcase
    end

    assign mode_ok = (waveform_mode_select_i == pwm_timer_pkg::MODE_TOP_CAPTURE) ||
                     (waveform_mode_select_i == pwm_timer_pkg::MODE_TOP_COMPARE_A);
    assign top = (waveform_mode_select_i == pwm_timer_pkg::MODE_TOP_COMPARE_A) ?
                 ocr_a_reg : capture_top_register_i; // see (R1) (R14)
    assign at_top = (cnt_reg == top);
    assign at_bottom = (cnt_reg == pwm_timer_pkg::BOTTOM);
    // equality with the live count: a compare above TOP is never reached
    assign match_a = (cnt_reg == ocr_a_reg); // see (R3) (R6)
    assign match_b = (cnt_reg == ocr_b_reg); // see (R3) (R6)

    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        unique case (dir_reg)
            pwm_timer_pkg::DIR_UP: begin
                if (at_top) begin
                    // leave TOP on this tick so it shows for exactly one tick
                    dir_next = pwm_timer_pkg::DIR_DOWN; // see (R2)
                    if (!at_bottom) begin
                        cnt_next = cnt_reg - CNT_W'(1); // see (R2)
                    end
                end else begin
                    cnt_next = cnt_reg + CNT_W'(1); // see (R1)
                end
            end
            pwm_timer_pkg::DIR_HOLD_TOP: begin
                dir_next = pwm_timer_pkg::DIR_DOWN;
            end
            pwm_timer_pkg::DIR_DOWN: begin
                if (at_bottom) begin
                    cnt_next = cnt_reg + CNT_W'(1); // see (R15)
                    dir_next = pwm_timer_pkg::DIR_UP;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1); // see (R15)
                end
            end
            default: begin
                dir_next = pwm_timer_pkg::DIR_UP;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= pwm_timer_pkg::COUNT_RESET;
            dir_reg <= pwm_timer_pkg::DIR_UP;
        end else if (tick && mode_ok) begin
            cnt_reg <= cnt_next; // see (R13)
            dir_reg <= dir_next;
        end
    end

    // compare double buffer: load at bottom
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ocr_a_reg <= pwm_timer_pkg::COMPARE_RESET;
            ocr_b_reg <= pwm_timer_pkg::COMPARE_RESET;
        end else if (tick && mode_ok && at_bottom) begin
            ocr_a_reg <= compare_a_buffer_i; // see (R4)
            ocr_b_reg <= compare_b_buffer_i; // see (R4)
        end
    end

    always_comb begin
        flag_set = '0;
        if (tick && mode_ok) begin
            flag_set.overflow = at_bottom; // see (R4)
            flag_set.compare_a = match_a; // see (R3) (R5)
            flag_set.compare_b = match_b; // see (R3)
            flag_set.capture = at_top &&
                (waveform_mode_select_i == pwm_timer_pkg::MODE_TOP_CAPTURE); // see (R5)
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flag_set | (flags_reg & ~flag_clear_i);
        end
    end

    // waveform: up-match and down-match move the level opposite ways
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wave_reg <= 2'h0;
        end else if (tick && mode_ok) begin
            if (at_top && ocr_a_reg == top) begin
                wave_reg[0] <= match_level(output_mode_bits_i.mode_a, 1'b0); // see (R12)
            end else if (match_a && !at_bottom) begin
                wave_reg[0] <= match_level(output_mode_bits_i.mode_a,
                    dir_reg == pwm_timer_pkg::DIR_UP); // see (R10)
            end else if (at_bottom && match_a) begin
                wave_reg[0] <= match_level(output_mode_bits_i.mode_a, 1'b1); // see (R12)
            end
            if (at_top && ocr_b_reg == top) begin
                wave_reg[1] <= match_level(output_mode_bits_i.mode_b, 1'b0); // see (R12)
            end else if (match_b && !at_bottom) begin
                wave_reg[1] <= match_level(output_mode_bits_i.mode_b,
                    dir_reg == pwm_timer_pkg::DIR_UP); // see (R10)
            end else if (at_bottom && match_b) begin
                wave_reg[1] <= match_level(output_mode_bits_i.mode_b, 1'b1); // see (R12)
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pin_level_o <= 2'h0;
            pin_oe_o <= 2'h0;
        end else begin
            pin_level_o[0] <= wave_reg[0];
            pin_level_o[1] <= wave_reg[1];
            pin_oe_o[0] <= pin_direction_bit_i[0] &&
                output_mode_bits_i.mode_a[1]; // see (R8) (R9)
            pin_oe_o[1] <= pin_direction_bit_i[1] &&
                output_mode_bits_i.mode_b[1]; // see (R8) (R9)
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pwm_counter_o <= pwm_timer_pkg::COUNT_RESET;
            compare_register_a_o <= pwm_timer_pkg::COMPARE_RESET;
            compare_register_b_o <= pwm_timer_pkg::COMPARE_RESET;
            flags_o <= '0;
            pwm_outputs_o <= 2'h0;
            timer_tick_o <= 1'b0;
        end else begin
            pwm_counter_o <= cnt_reg;
            compare_register_a_o <= ocr_a_reg;
            compare_register_b_o <= ocr_b_reg;
            flags_o <= flags_reg;
            pwm_outputs_o <= wave_reg;
            timer_tick_o <= tick;
        end
    end
endmodule : dual_slope_symmetric_pwm_timer

// >>> logic/pwm_timer_pkg.sv
/*
 * constants and types for the dual-slope symmetric pwm timer.
 * assumes a single 40 MHz system clock and no register bus.
 */
package pwm_timer_pkg;
    localparam int CNT_W = 16;
    localparam logic [3:0] MODE_TOP_CAPTURE = 4'h8;
    localparam logic [3:0] MODE_TOP_COMPARE_A = 4'h9;
    localparam logic [1:0] OUT_MODE_NONINV = 2'h2;
    localparam logic [1:0] OUT_MODE_INV = 2'h3;
    localparam logic [2:0] PRESCALE_OFF = 3'h0;
    localparam logic [2:0] PRESCALE_1 = 3'h1;
    localparam logic [2:0] PRESCALE_8 = 3'h2;
    localparam logic [2:0] PRESCALE_64 = 3'h3;
    localparam logic [2:0] PRESCALE_256 = 3'h4;
    localparam logic [2:0] PRESCALE_1024 = 3'h5;
    localparam int PRESCALE_W = 10;
    localparam logic [CNT_W-1:0] BOTTOM = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] COMPARE_RESET = 16'h0000;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 10'h000;

    typedef enum logic [2:0] {
        DIR_UP = 3'b001,
        DIR_HOLD_TOP = 3'b010,
        DIR_DOWN = 3'b100
    } dir_state_e;

    typedef struct packed {
        logic overflow;
        logic compare_a;
        logic compare_b;
        logic capture;
    } timer_flags_s;

    typedef struct packed {
        logic [1:0] mode_a;
        logic [1:0] mode_b;
    } output_modes_s;
endpackage : pwm_timer_pkg

// >>> tb/dual_slope_symmetric_pwm_timer_assertions.sv
/* port checker for the dual-slope pwm timer.
   bound to every timer instance; sees its ports only. */
`timescale 1ns/1ps
module pwm_timer_checker #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] waveform_mode_select_i,
    input wire logic [2:0] prescale_select_i,
    input wire logic [CNT_W-1:0] capture_top_register_i,
    input wire logic [1:0] pin_direction_bit_i,
    input wire logic [CNT_W-1:0] pwm_counter_o,
    input wire logic [CNT_W-1:0] compare_register_a_o,
    input wire logic [CNT_W-1:0] compare_register_b_o,
    input wire pwm_timer_pkg::timer_flags_s flags_o,
    input wire logic [1:0] pin_oe_o,
    input wire logic timer_tick_o
);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_step_by_one: assert property (pwm_counter_o != $past(pwm_counter_o) |->
        pwm_counter_o == $past(pwm_counter_o) + ONE || pwm_counter_o == $past(pwm_counter_o) - ONE)
        else $error("counter jumped");
    a_turn_at_top: assert property (pwm_counter_o == compare_register_a_o
        && waveform_mode_select_i == pwm_timer_pkg::MODE_TOP_COMPARE_A
        && pwm_counter_o == $past(pwm_counter_o) + ONE |=> pwm_counter_o <= $past(pwm_counter_o))
        else $error("counter passed top");
    a_top_one_tick: assert property (timer_tick_o
        && pwm_counter_o == compare_register_a_o && pwm_counter_o != '0
        && waveform_mode_select_i == pwm_timer_pkg::MODE_TOP_COMPARE_A
        |=> pwm_counter_o == $past(pwm_counter_o) - ONE)
        else $error("top held too long");
    a_turn_at_bottom: assert property (pwm_counter_o == '0
        && $past(pwm_counter_o) == ONE |=> pwm_counter_o <= ONE)
        else $error("counter passed bottom");
    a_overflow_at_bottom: assert property ($rose(flags_o.overflow)
        |-> pwm_counter_o == '0
        || $past(pwm_counter_o) == '0 || $past(pwm_counter_o, 2) == '0)
        else $error("overflow away from bottom");
    a_match_sets_b: assert property ($rose(flags_o.compare_b) |->
        pwm_counter_o == compare_register_b_o
        || $past(pwm_counter_o) == $past(compare_register_b_o)
        || $past(pwm_counter_o, 2) == $past(compare_register_b_o, 2)
        || $past(pwm_counter_o, 3) == $past(compare_register_b_o, 3))
        else $error("b flag without match");
    a_b_above_top: assert property (compare_register_b_o >
        (waveform_mode_select_i == pwm_timer_pkg::MODE_TOP_COMPARE_A
        ? compare_register_a_o : capture_top_register_i)
        && $past(compare_register_b_o, 3) == compare_register_b_o
        |-> !$rose(flags_o.compare_b)) else $error("match above top");
    a_tick_every_cycle: assert property ($past(rst_n_i)
        && $past(prescale_select_i) == pwm_timer_pkg::PRESCALE_1
        && $past(prescale_select_i, 2) == pwm_timer_pkg::PRESCALE_1 |-> timer_tick_o)
        else $error("undivided tick missing");
    a_pin_released: assert property ((pin_oe_o & ~$past(pin_direction_bit_i)
        & ~$past(pin_direction_bit_i, 2)) == 2'h0) else $error("input pin driven");
endmodule : pwm_timer_checker
bind dual_slope_symmetric_pwm_timer pwm_timer_checker #(.CNT_W(CNT_W)) chk (.*);

// >>> tb/dual_slope_symmetric_pwm_timer_bench.sv
/* self-checking bench for the dual-slope pwm timer.
   assumes the port checker bind and the pin load model. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module dual_slope_symmetric_pwm_timer_bench;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] mode = 4'h9;
    logic [2:0] psel = 3'h1;
    logic [15:0] cmpa = 16'h6, cmpb = 16'h2, cap = 16'h0, cnt, c0, ra, rb;
    logic [1:0] dir = 2'h3, pwm, lvl, oe, pad;
    logic tick;
    pwm_timer_pkg::output_modes_s om = 4'ha;
    pwm_timer_pkg::timer_flags_s fclr = '0, flags;
    int n_mismatch = 0, n_compared = 0, hi, hp, ho, mx, p;
    int div[5] = '{1, 8, 64, 256, 1024};
    always #12.5 ref_clk_i = ~ref_clk_i;
    dual_slope_symmetric_pwm_timer uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .waveform_mode_select_i(mode), .prescale_select_i(psel), .output_mode_bits_i(om),
        .compare_a_buffer_i(cmpa), .compare_b_buffer_i(cmpb), .capture_top_register_i(cap),
        .pin_direction_bit_i(dir), .flag_clear_i(fclr), .pwm_counter_o(cnt),
        .compare_register_a_o(ra), .compare_register_b_o(rb), .flags_o(flags),
        .pwm_outputs_o(pwm), .pin_level_o(lvl), .pin_oe_o(oe), .timer_tick_o(tick));
    pin_load_model load (.ref_clk_i(ref_clk_i), .level_i(lvl), .oe_i(oe), .pad_o(pad));
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic restart();
        rst_n_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
    endtask : restart
    // peak count and high cycles of channel b waveform, pad and enable
    task automatic watch(input int n);
        mx = 0;
        hi = 0;
        hp = 0;
        ho = 0;
        repeat (n) begin
            @(posedge ref_clk_i);
            #1;
            mx = (int'(cnt) > mx) ? int'(cnt) : mx;
            hi += int'(pwm[1]);
            hp += int'(pad[1]);
            ho += int'(oe[1]);
            `CHK($isunknown({cnt, pwm, pad, oe}), 1'b0)
        end
    endtask : watch
    // cycles between two overflow flag settings, clearing in between
    task automatic period();
        p = 0;
        while (flags.overflow !== 1'b1 && p < 30000) begin
            @(posedge ref_clk_i);
            #1;
            p++;
        end
        @(negedge ref_clk_i);
        fclr.overflow = 1'b1;
        @(negedge ref_clk_i);
        fclr.overflow = 1'b0;
        p = 1;
        do begin
            @(posedge ref_clk_i);
            #1;
            p++;
        end while (flags.overflow !== 1'b1 && p < 30000);
    endtask : period
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        n_mismatch++;
        complete_run();
    end
    initial begin
        restart();
        @(posedge ref_clk_i);
        #1;
        `CHK({cnt, flags, oe, pwm}, 24'h00000c)
        for (int i = 0; i < 6; i++) begin
            @(negedge ref_clk_i);
            cmpb = (i % 3 == 2) ? 16'h6 : 16'(2 * (i % 3));
            om.mode_b = (i < 3) ? pwm_timer_pkg::OUT_MODE_NONINV : pwm_timer_pkg::OUT_MODE_INV;
            dir[1] = (i < 3);
            restart();
            watch(24);
            watch(24);
            `CHK(hi, (i < 3) ? 4 * int'(cmpb) : 24 - 4 * int'(cmpb))
            `CHK(ho, (i < 3) ? 24 : 0)
            // a released pad toggles every cycle in the load model
            `CHK(hp, (i < 3) ? hi : 12)
            `CHK(pwm[0], 1'b1)
            `CHK({mx, flags, ra, rb}, {32'd6, 4'he, 16'h6, cmpb})
            $display("duty test %0d done", i);
        end
        @(negedge ref_clk_i);
        mode = pwm_timer_pkg::MODE_TOP_CAPTURE;
        cap = 16'h5;
        cmpa = 16'h2;
        cmpb = 16'h9;
        restart();
        // drop flags raised while the compare registers still held their reset value
        @(negedge ref_clk_i);
        fclr = 4'hf;
        @(negedge ref_clk_i);
        fclr = 4'h0;
        watch(48);
        `CHK(mx, 5)
        `CHK(flags, 4'hd)
        @(negedge ref_clk_i);
        mode = 4'h0;
        repeat (3) @(negedge ref_clk_i);
        c0 = cnt;
        watch(20);
        `CHK(cnt, c0)
        $display("capture and freeze tests done");
        @(negedge ref_clk_i);
        mode = pwm_timer_pkg::MODE_TOP_COMPARE_A;
        cmpa = 16'h6;
        cmpb = 16'h2;
        restart();
        for (int k = 0; k < 5; k++) begin
            @(negedge ref_clk_i);
            psel = 3'(k + 1);
            period();
            period();
            `CHK(p, 2 * div[k] * 6)
        end
        @(negedge ref_clk_i);
        psel = pwm_timer_pkg::PRESCALE_1;
        cmpa = 16'h4;
        period();
        period();
        `CHK({p, tick}, {32'd8, 1'b1})
        $display("period tests done");
        complete_run();
    end
endmodule : dual_slope_symmetric_pwm_timer_bench

// >>> tb/pin_load_model.sv
/* pin output stage with external load.
   fed by the timer's pin level and enable. */
`timescale 1ns/1ps
module pin_load_model (
    input wire logic ref_clk_i,
    input wire logic [1:0] level_i,
    input wire logic [1:0] oe_i,
    output logic [1:0] pad_o
);
    logic [1:0] last_reg = 2'h0;
    always_ff @(posedge ref_clk_i) begin
        last_reg <= pad_o;
    end
    // an undriven pad toggles so a stale level never passes
    assign pad_o = (oe_i & level_i) | (~oe_i & ~last_reg);
endmodule : pin_load_model
